// [design/wtsi_pkg.sv]
package wtsi_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] WTSI_OFS_CTRL      = 12'h060;
    localparam logic [11:0] WTSI_OFS_WRAP_MODE = 12'h064;
    localparam logic [11:0] WTSI_OFS_EV_CLEAR  = 12'h06c;
    localparam logic [11:0] WTSI_OFS_EV_STATUS = 12'h070;
    localparam logic [11:0] WTSI_OFS_MASK_SET  = 12'h074;
    localparam logic [11:0] WTSI_OFS_MASK_CLR  = 12'h078;
    localparam logic [11:0] WTSI_OFS_MASK      = 12'h07c;
    localparam logic [11:0] WTSI_OFS_SECONDS   = 12'h080;
    localparam logic [11:0] WTSI_OFS_ALARM     = 12'h084;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int WTSI_EV_ALARM       = 0;
    localparam int WTSI_EV_CNT_ON      = 1;
    localparam int WTSI_EV_CNT_OFF     = 2;
    localparam int WTSI_EV_ALM_ON      = 3;
    localparam int WTSI_EV_ALM_OFF     = 4;
    localparam int WTSI_ST_WR_PEND     = 5;
    localparam int WTSI_ST_CNT_LIVE    = 8;
    localparam int WTSI_ST_ALM_LIVE    = 9;
    localparam int WTSI_NEV            = 5;
    localparam int WTSI_CTL_CNT_ON     = 1;
    localparam int WTSI_CTL_CNT_OFF    = 2;
    localparam int WTSI_CTL_ALM_ON     = 3;
    localparam int WTSI_CTL_ALM_OFF    = 4;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [31:0] WTSI_DAY_LAST  = 32'ha8bfffff;
    localparam logic [31:0] WTSI_DAY_LIMIT = 32'ha8c00000;
    localparam logic [31:0] WTSI_FULL_LAST = 32'h0fffffff;
    localparam logic [31:0] WTSI_ZERO      = 32'h00000000;
    localparam int          WTSI_SYNC_LEN  = 3;
endpackage

// [design/wtsi_slow.sv]
`timescale 1ns/1ps
// slow-clock side: counter, alarm compare, enables. requests arrive as toggles.
module wtsi_slow
    import wtsi_pkg::*;
(
    input  wire logic        slow_clk,
    input  wire logic        nrst,
    input  wire logic        wrap_select,
    input  wire logic        cnt_on_tgl,
    input  wire logic        cnt_off_tgl,
    input  wire logic        alm_on_tgl,
    input  wire logic        alm_off_tgl,
    input  wire logic        sec_wr_tgl,
    input  wire logic [31:0] sec_wr_val,
    input  wire logic        alm_wr_tgl,
    input  wire logic [31:0] alm_wr_val,
    output logic             cnt_live,
    output logic             alm_live,
    output logic             match_tgl,
    output logic             sec_ack_tgl,
    output logic [31:0]      seconds,
    output logic [31:0]      alarm_val
);
    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [5:0]  seen;
        logic [2:0]  wr_s;
        logic        wrap;
        logic        cnt_on;
        logic        alm_on;
        logic        match_t;
        logic        ack_t;
        logic [31:0] secs;
        logic [31:0] alm;
    } wtsi_slow_s;

    wtsi_slow_s q, d;
    logic [5:0] tin;
    logic [5:0] ev;

    assign tin = {alm_wr_tgl, sec_wr_tgl, alm_off_tgl, alm_on_tgl, cnt_off_tgl, cnt_on_tgl};

    always_comb begin
        d  = q;
        d.s1 = tin;
        d.s2 = q.s1;
        ev = q.s2 ^ q.seen;
        d.seen = q.s2;
        // mode bit is quasi-static but still crosses clocks; filter before use
        d.wr_s = {q.wr_s[1:0], wrap_select};
        if (q.wr_s[2] == q.wr_s[1]) begin
            d.wrap = q.wr_s[1];
        end
        // disable wins when both arrive together
        if (ev[1]) begin
            d.cnt_on = 1'b0;
        end else if (ev[0]) begin
            d.cnt_on = 1'b1;
        end
        if (ev[3]) begin
            d.alm_on = 1'b0;
        end else if (ev[2]) begin
            d.alm_on = 1'b1;
        end
        if (q.cnt_on) begin
            if ((!q.wrap && q.secs == WTSI_DAY_LAST) ||
                (q.wrap && q.secs == WTSI_FULL_LAST)) begin
                d.secs = WTSI_ZERO;
            end else begin
                d.secs = q.secs + 32'h00000001;
            end
        end
        if (q.alm_on && q.secs == q.alm) begin
            d.match_t = ~q.match_t;
        end
        if (ev[4]) begin
            // in day mode, values are range-checked in the bus domain before launch; wrap mode passes any value
            d.secs  = sec_wr_val;
            d.ack_t = ~q.ack_t;
        end
        if (ev[5]) begin
            d.alm = alm_wr_val;
        end
    end

    always_ff @(posedge slow_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt_live    = q.cnt_on;
    assign alm_live    = q.alm_on;
    assign match_tgl   = q.match_t;
    assign sec_ack_tgl = q.ack_t;
    assign seconds     = q.secs;
    assign alarm_val   = q.alm;
endmodule

// [design/wtsi_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - wrap_select 0: counter returns to zero after holding 0xa8bfffff.
// - wrap_select 1: counter returns to zero after holding 0x0fffffff.
// - writing ones to event_clear clears those flags; zeros leave them.
// - alarm match sets status bit 0, sticky until cleared.
// - counter enable taking effect sets status bit 1, sticky.
// - counter disable taking effect sets status bit 2, sticky.
// - alarm enable taking effect sets status bit 3, sticky.
// - alarm disable taking effect sets status bit 4, sticky.
// - status bit 5 high while a seconds write crosses to slow clock.
// - status bit 8 shows live counter enable state.
// - status bit 9 shows live alarm enable state.
// - each mask bit gates its event flag onto the interrupt.
// - in day mode, seconds writes at or above 0xa8c00000 are dropped.
module wtsi_top
    import wtsi_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        slow_clk,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic [31:0]      seconds
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wrap;
        logic [4:0]  flags;
        logic [4:0]  mask;
        logic        cnt_on_t;
        logic        cnt_off_t;
        logic        alm_on_t;
        logic        alm_off_t;
        logic        sec_t;
        logic [31:0] sec_val;
        logic        alm_t;
        logic [31:0] alm_val;
        logic        pend;
        logic [2:0]  cl_s;
        logic [2:0]  al_s;
        logic [2:0]  mt_s;
        logic [2:0]  ak_s;
        logic        cl_v;
        logic        al_v;
        logic        mt_v;
        logic        ak_v;
        logic [31:0] rdata;
    } wtsi_top_s;

    wtsi_top_s q, d;

    logic        cnt_live;
    logic        alm_live;
    logic        match_tgl;
    logic        ack_tgl;
    logic [31:0] alarm_val;
    logic        wr_en;
    logic        rd_en;
    logic [4:0]  ev_set;
    logic        cl_new;
    logic        al_new;

    wtsi_slow u_slow (
        .slow_clk    (slow_clk),
        .nrst        (nrst),
        .wrap_select (q.wrap),
        .cnt_on_tgl  (q.cnt_on_t),
        .cnt_off_tgl (q.cnt_off_t),
        .alm_on_tgl  (q.alm_on_t),
        .alm_off_tgl (q.alm_off_t),
        .sec_wr_tgl  (q.sec_t),
        .sec_wr_val  (q.sec_val),
        .alm_wr_tgl  (q.alm_t),
        .alm_wr_val  (q.alm_val),
        .cnt_live    (cnt_live),
        .alm_live    (alm_live),
        .match_tgl   (match_tgl),
        .sec_ack_tgl (ack_tgl),
        .seconds     (seconds),
        .alarm_val   (alarm_val)
    );

    // ------------------------------------------------------------
    // bus: zero-wait slave, answer in the access cycle
    // ------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign prdata  = q.rdata;
    assign irq     = |(q.flags & q.mask);

    always_comb begin
        d = q;
        // three-stage sync; a change counts once stage 2 and 3 agree
        d.cl_s = {q.cl_s[1:0], cnt_live};
        d.al_s = {q.al_s[1:0], alm_live};
        d.mt_s = {q.mt_s[1:0], match_tgl};
        d.ak_s = {q.ak_s[1:0], ack_tgl};
        cl_new = (q.cl_s[2] == q.cl_s[1]) ? q.cl_s[1] : q.cl_v;
        al_new = (q.al_s[2] == q.al_s[1]) ? q.al_s[1] : q.al_v;
        d.cl_v = cl_new;
        d.al_v = al_new;
        if (q.mt_s[2] == q.mt_s[1]) begin
            d.mt_v = q.mt_s[1];
        end
        if (q.ak_s[2] == q.ak_s[1]) begin
            d.ak_v = q.ak_s[1];
        end
        ev_set = '0;
        ev_set[WTSI_EV_ALARM]   = d.mt_v != q.mt_v;
        ev_set[WTSI_EV_CNT_ON]  = cl_new && !q.cl_v;
        ev_set[WTSI_EV_CNT_OFF] = !cl_new && q.cl_v;
        ev_set[WTSI_EV_ALM_ON]  = al_new && !q.al_v;
        ev_set[WTSI_EV_ALM_OFF] = !al_new && q.al_v;
        if (d.ak_v != q.ak_v) begin
            d.pend = 1'b0;
        end
        if (wr_en) begin
            if (paddr == WTSI_OFS_WRAP_MODE) begin
                d.wrap = pwdata[0];
            end else if (paddr == WTSI_OFS_EV_CLEAR) begin
                d.flags = q.flags & ~pwdata[WTSI_NEV-1:0];
            end else if (paddr == WTSI_OFS_MASK_SET) begin
                d.mask = q.mask | pwdata[WTSI_NEV-1:0];
            end else if (paddr == WTSI_OFS_MASK_CLR) begin
                d.mask = q.mask & ~pwdata[WTSI_NEV-1:0];
            end else if (paddr == WTSI_OFS_CTRL) begin
                // one toggle per request; the slow side lets disable win
                if (pwdata[WTSI_CTL_CNT_ON]) begin
                    d.cnt_on_t = ~q.cnt_on_t;
                end
                if (pwdata[WTSI_CTL_CNT_OFF]) begin
                    d.cnt_off_t = ~q.cnt_off_t;
                end
                if (pwdata[WTSI_CTL_ALM_ON]) begin
                    d.alm_on_t = ~q.alm_on_t;
                end
                if (pwdata[WTSI_CTL_ALM_OFF]) begin
                    d.alm_off_t = ~q.alm_off_t;
                end
            end else if (paddr == WTSI_OFS_SECONDS) begin
                // only while stopped and idle; value held stable for crossing
                if (!q.cl_v && !q.pend &&
                    (q.wrap || pwdata < WTSI_DAY_LIMIT)) begin
                    d.sec_val = pwdata;
                    d.sec_t   = ~q.sec_t;
                    d.pend    = 1'b1;
                end
            end else if (paddr == WTSI_OFS_ALARM) begin
                if (!q.al_v && (q.wrap || pwdata < WTSI_DAY_LIMIT)) begin
                    d.alm_val = pwdata;
                    d.alm_t   = ~q.alm_t;
                end
            end
        end
        // set wins over a clear in the same cycle
        d.flags = d.flags | ev_set;
        if (rd_en) begin
            d.rdata = '0;
            if (paddr == WTSI_OFS_WRAP_MODE) begin
                d.rdata[0] = q.wrap;
            end else if (paddr == WTSI_OFS_EV_STATUS) begin
                d.rdata[WTSI_NEV-1:0]    = q.flags;
                d.rdata[WTSI_ST_WR_PEND]  = q.pend;
                d.rdata[WTSI_ST_CNT_LIVE] = q.cl_v;
                d.rdata[WTSI_ST_ALM_LIVE] = q.al_v;
            end else if (paddr == WTSI_OFS_MASK) begin
                d.rdata[WTSI_NEV-1:0] = q.mask;
            end else if (paddr == WTSI_OFS_SECONDS) begin
                // multi-bit word from slow domain; stable only while stopped
                d.rdata = seconds;
            end else if (paddr == WTSI_OFS_ALARM) begin
                d.rdata = alarm_val;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import wtsi_pkg::*;
    logic        sys_clk, nrst, slow_clk, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seconds, st;
    int          n_errors, n_compared;

    wtsi_top i_dut (.sys_clk, .nrst, .slow_clk, .psel, .penable, .pwrite, .paddr,
                    .pwdata, .prdata, .pready, .pslverr, .irq, .seconds);
    // ----------
    // clocks and bus tasks
    // ----------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        slow_clk = 1'b0;
        #7;
        forever #155 slow_clk = ~slow_clk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        st = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // completion crosses from the slow clock, so the wait is bounded, not fixed
    task automatic poll(input int b, input logic v);
        for (int i = 0; i < 200; i++) begin
            apb(1'b0, WTSI_OFS_EV_STATUS, 32'h0);
            if (st[b] === v) break;
        end
        check(st[b], v);
    endtask
    task automatic wait_wrap;
        for (int i = 0; i < 4000 && seconds >= 32'h100; i++) @(posedge sys_clk);
    endtask
    task automatic results;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_regs;
        apb(1'b0, WTSI_OFS_WRAP_MODE, 32'h0);
        check(st, 32'h0);
        apb(1'b0, WTSI_OFS_EV_STATUS, 32'h0);
        check(st, 32'h0);
        apb(1'b0, 12'h068, 32'h0);
        check(st, 32'h0);
    endtask
    task automatic t_mask;
        apb(1'b1, WTSI_OFS_MASK_SET, 32'h1f);
        apb(1'b1, WTSI_OFS_MASK_CLR, 32'h05);
        apb(1'b0, WTSI_OFS_MASK, 32'h0);
        check(st, 32'h1a);
        apb(1'b1, WTSI_OFS_MASK_CLR, 32'h1f);
    endtask
    task automatic t_day;
        apb(1'b1, WTSI_OFS_SECONDS, WTSI_DAY_LIMIT);
        apb(1'b1, WTSI_OFS_SECONDS, 32'ha8bffff0);
        apb(1'b0, WTSI_OFS_EV_STATUS, 32'h0);
        check(st[WTSI_ST_WR_PEND], 1'b1);
        poll(WTSI_ST_WR_PEND, 1'b0);
        check(seconds, 32'ha8bffff0);
        apb(1'b1, WTSI_OFS_MASK_SET, 32'h02);
        apb(1'b1, WTSI_OFS_CTRL, 32'h002);
        poll(WTSI_EV_CNT_ON, 1'b1);
        check(st[9:0], 10'h102);
        check(irq, 1'b1);
        apb(1'b1, WTSI_OFS_EV_CLEAR, 32'h1f);
        apb(1'b0, WTSI_OFS_EV_STATUS, 32'h0);
        check(st[4:0], 5'h00);
        check(irq, 1'b0);
        wait_wrap();
        check(seconds < 32'h100, 1'b1);
        apb(1'b1, WTSI_OFS_CTRL, 32'h004);
        poll(WTSI_EV_CNT_OFF, 1'b1);
        check(st[9:0], 10'h004);
    endtask
    task automatic t_alarm;
        apb(1'b1, WTSI_OFS_SECONDS, 32'h10);
        poll(WTSI_ST_WR_PEND, 1'b0);
        apb(1'b1, WTSI_OFS_ALARM, 32'h20);
        apb(1'b1, WTSI_OFS_CTRL, 32'h00a);
        poll(WTSI_EV_ALARM, 1'b1);
        check(st[9:0], 10'h30f);
        apb(1'b1, WTSI_OFS_EV_CLEAR, 32'h01);
        apb(1'b1, WTSI_OFS_CTRL, 32'h014);
        poll(WTSI_EV_ALM_OFF, 1'b1);
        check(st[9:0], 10'h01e);
    endtask
    task automatic t_full;
        apb(1'b1, WTSI_OFS_WRAP_MODE, 32'h1);
        apb(1'b1, WTSI_OFS_SECONDS, 32'h0ffffff8);
        poll(WTSI_ST_WR_PEND, 1'b0);
        check(seconds, 32'h0ffffff8);
        apb(1'b1, WTSI_OFS_CTRL, 32'h002);
        wait_wrap();
        check(seconds < 32'h100, 1'b1);
        apb(1'b1, WTSI_OFS_CTRL, 32'h004);
        poll(WTSI_ST_CNT_LIVE, 1'b0);
        apb(1'b1, WTSI_OFS_SECONDS, WTSI_DAY_LIMIT);
        poll(WTSI_ST_WR_PEND, 1'b0);
        check(seconds, WTSI_DAY_LIMIT);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        results();
    end
    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_mask();
        t_day();
        t_alarm();
        t_full();
        results();
    end
endmodule

// [test/wtsi_top_asserts.sv]
`timescale 1ns/1ps
module wtsi_top_asserts
    import wtsi_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        slow_clk,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic [31:0] seconds
);
    // ----------
    // shadow of what software wrote
    // ----------
    logic       wrap_q;
    logic [4:0] mask_q;
    logic       wr_ev;
    assign wr_ev = psel && penable && pwrite && pready;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrap_q <= 1'b0;
            mask_q <= 5'h00;
        end else if (wr_ev) begin
            if (paddr == WTSI_OFS_WRAP_MODE) wrap_q <= pwdata[0];
            if (paddr == WTSI_OFS_MASK_SET) mask_q <= mask_q | pwdata[4:0];
            if (paddr == WTSI_OFS_MASK_CLR) mask_q <= mask_q & ~pwdata[4:0];
        end
    end
    // ----------
    // properties
    // ----------
    sequence s_rd(a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    sequence s_clear_all;
        wr_ev && paddr == WTSI_OFS_EV_CLEAR && pwdata[4:0] == 5'h1f;
    endsequence
    property p_mode_read;
        @(posedge sys_clk) disable iff (!nrst) s_rd(WTSI_OFS_WRAP_MODE) |-> prdata == {31'h0, wrap_q};
    endproperty
    property p_mask_read;
        @(posedge sys_clk) disable iff (!nrst) s_rd(WTSI_OFS_MASK) |-> prdata == {27'h0, mask_q};
    endproperty
    property p_irq_off;
        @(posedge sys_clk) disable iff (!nrst) mask_q == 5'h00 |-> !irq;
    endproperty
    property p_irq_cause;
        @(posedge sys_clk) disable iff (!nrst) irq |-> mask_q != 5'h00;
    endproperty
    property p_bus_ok;
        @(posedge sys_clk) disable iff (!nrst) psel && penable |-> pready && !pslverr;
    endproperty
    // slack covers the flag register; irq itself is combinational from flags and mask
    property p_irq_clear;
        @(posedge sys_clk) disable iff (!nrst) s_clear_all |-> ##[2:4] !irq;
    endproperty
    property p_day_wrap;
        @(posedge slow_clk) disable iff (!nrst)
            !wrap_q && seconds == WTSI_DAY_LAST |=> seconds == WTSI_ZERO || $stable(seconds);
    endproperty
    property p_full_wrap;
        @(posedge slow_clk) disable iff (!nrst)
            wrap_q && seconds == WTSI_FULL_LAST |=> seconds == WTSI_ZERO || $stable(seconds);
    endproperty
    property p_day_range;
        @(posedge slow_clk) disable iff (!nrst)
            !wrap_q && seconds < WTSI_DAY_LIMIT |=> seconds < WTSI_DAY_LIMIT;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
    a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
    a_irq_off: assert property (p_irq_off) else $error("irq with mask clear");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without mask");
    a_irq_clear: assert property (p_irq_clear) else $error("irq after clear");
    a_day_wrap: assert property (p_day_wrap) else $error("day wrap wrong");
    a_full_wrap: assert property (p_full_wrap) else $error("full wrap wrong");
    a_day_range: assert property (p_day_range) else $error("day range left");
    a_bus_ok: assert property (p_bus_ok) else $error("bus answer wrong");
endmodule

bind wtsi_top wtsi_top_asserts i_chk (.sys_clk, .nrst, .slow_clk, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .seconds);
